// >>> design/lmc_done_flag.sv
`timescale 1ns/100ps
`default_nettype none
module lmc_done_flag (
  input  wire logic clk,      // clock
  input  wire logic rst_n,    // sync reset
  input  wire logic start,    // conversion started
  input  wire logic done,     // conversion finished
  input  wire logic clr,      // host writes zero
  output logic      flag_reg  // status bit
);
  // set beats clear and start; start clears to show work in progress
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      flag_reg <= 1'b0;
    end else if (done) begin
      flag_reg <= 1'b1;
    end else if (start || clr) begin
      flag_reg <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// >>> design/lmc_pkg.sv
package lmc_pkg;

  // ----------------------------------------------------------------------
  // map geometry
  // ----------------------------------------------------------------------
  localparam int          ROW_BYTES      = 8;
  localparam int          WORD_BYTES     = 2;
  localparam logic [7:0]  UPPER_BASE     = 8'h80;

  // ----------------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0]  MAIN_CONTROL_OFS        = 8'h00;
  localparam logic [7:0]  OPERATING_OPTIONS_OFS   = 8'h01;
  localparam logic [7:0]  SCRATCH_BYTE_OFS        = 8'h02;
  localparam logic [7:0]  LUT_POINTER_OFS         = 8'h03;
  localparam logic [7:0]  TEMPERATURE_READING_OFS = 8'h04;
  localparam logic [7:0]  SUPPLY_READING_OFS      = 8'h06;
  localparam logic [7:0]  OUTPUT_VALUE_ROW_OFS    = 8'h10;
  localparam logic [7:0]  POWERUP_VALUE_ROW_OFS   = 8'h78;

  // ----------------------------------------------------------------------
  // main control fields and reset values
  // ----------------------------------------------------------------------
  localparam int          TEMP_DONE_BIT   = 7;
  localparam int          SUPPLY_DONE_BIT = 6;
  localparam int          GP_HI_BIT       = 5;
  localparam int          GP_LO_BIT       = 4;
  localparam int          TSEL_HI_BIT     = 3;
  localparam int          TSEL_LO_BIT     = 0;
  localparam logic [7:0]  MAIN_CONTROL_RST = 8'h00;
  localparam logic [7:0]  OPTIONS_RST      = 8'h40;
  localparam logic [7:0]  SCRATCH_RST      = 8'h00;
  localparam logic [7:0]  POINTER_RST      = 8'h00;

  // ----------------------------------------------------------------------
  // table select codes
  // ----------------------------------------------------------------------
  localparam logic [3:0]  TSEL_FIRST = 4'h4;
  localparam logic [3:0]  TSEL_LAST  = 4'h7;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } lmc_access_type;

  typedef struct packed {
    logic       valid;
    logic [1:0] channel;
    logic [6:0] offset;
  } lmc_table_type;

endpackage

// >>> design/lmc_regs.sv
// Operation
// - The map is laid out in rows of eight bytes, each byte one address above the last.
// - A two-byte word takes two consecutive addresses, so words on a row step by two.
// - The main control register at address zero is volatile, read/write and resets to zero.
// - Bit 7 reads 0 during a temperature conversion and 1 once one has finished since last cleared.
// - Bit 6 reads 0 during a supply conversion and 1 once it has finished.
// - Bits 5:4 are plain storage with no effect on the device.
// - The table-select field in bits 3:0 picks which nonvolatile table is reachable.
// - Only codes 0100b to 0111b are usable, selecting the tables of channels 0 to 3.
// - The selected table appears to the host in the upper window 80h to FFh.
`timescale 1ns/100ps
`default_nettype none
module lmc_regs (
  input  wire logic                   clk,            // 40 MHz clock
  input  wire logic                   rst_n,          // sync reset, active low
  input  wire lmc_pkg::lmc_access_type host,          // host byte access
  input  wire logic                   temp_start,     // temperature conversion start
  input  wire logic                   temp_done,      // temperature conversion end
  input  wire logic                   supply_start,   // supply conversion start
  input  wire logic                   supply_done,    // supply conversion end
  input  wire logic [7:0]             table_rdata,    // byte from selected table
  output logic [7:0]                  rdata_reg,      // read data
  output logic                        rvalid_reg,     // read data valid
  output lmc_pkg::lmc_table_type      table_sel_reg,  // decoded table window
  output logic                        table_wr_reg,   // write into selected table
  output logic [7:0]                  table_wdata_reg,// table write data
  output logic [3:0]                  tsel_reg,       // table-select field
  output logic [1:0]                  gp_reg          // general storage bits
);

  // ----------------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------------
  logic       ctrl_hit;
  logic       upper_hit;
  logic       ctrl_wr;
  logic       ctrl_clr_temp;
  logic       ctrl_clr_supply;
  logic [2:0] row_byte;
  logic [4:0] row_index;
  logic       temp_flag;
  logic       supply_flag;
  logic [7:0] ctrl_value;
  logic       tsel_ok;

  // word registers are two byte slots, so byte decode alone places them
  assign row_byte  = host.addr[2:0];
  assign row_index = host.addr[7:3];
  assign ctrl_hit  = (row_index == lmc_pkg::MAIN_CONTROL_OFS[7:3]) && (row_byte == lmc_pkg::MAIN_CONTROL_OFS[2:0]);
  assign upper_hit = host.addr >= lmc_pkg::UPPER_BASE;
  assign ctrl_wr   = host.wr && ctrl_hit;
  assign ctrl_clr_temp   = ctrl_wr && !host.wdata[lmc_pkg::TEMP_DONE_BIT];
  assign ctrl_clr_supply = ctrl_wr && !host.wdata[lmc_pkg::SUPPLY_DONE_BIT];
  assign tsel_ok   = (tsel_reg >= lmc_pkg::TSEL_FIRST) && (tsel_reg <= lmc_pkg::TSEL_LAST);

  // ----------------------------------------------------------------------
  // conversion done flags
  // ----------------------------------------------------------------------
  lmc_done_flag u_temp_flag (
    .clk      (clk),
    .rst_n    (rst_n),
    .start    (temp_start),
    .done     (temp_done),
    .clr      (ctrl_clr_temp),
    .flag_reg (temp_flag)
  );

  lmc_done_flag u_supply_flag (
    .clk      (clk),
    .rst_n    (rst_n),
    .start    (supply_start),
    .done     (supply_done),
    .clr      (ctrl_clr_supply),
    .flag_reg (supply_flag)
  );

  // ----------------------------------------------------------------------
  // writable control fields
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      gp_reg <= lmc_pkg::MAIN_CONTROL_RST[lmc_pkg::GP_HI_BIT:lmc_pkg::GP_LO_BIT];
    end else if (ctrl_wr) begin
      gp_reg <= host.wdata[lmc_pkg::GP_HI_BIT:lmc_pkg::GP_LO_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tsel_reg <= lmc_pkg::MAIN_CONTROL_RST[lmc_pkg::TSEL_HI_BIT:lmc_pkg::TSEL_LO_BIT];
    end else if (ctrl_wr) begin
      tsel_reg <= host.wdata[lmc_pkg::TSEL_HI_BIT:lmc_pkg::TSEL_LO_BIT];
    end
  end

  assign ctrl_value = {temp_flag, supply_flag, gp_reg, tsel_reg};

  // ----------------------------------------------------------------------
  // upper window mapping
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      table_sel_reg <= '0;
    end else begin
      table_sel_reg.valid   <= tsel_ok;
      table_sel_reg.channel <= tsel_reg[1:0];
      table_sel_reg.offset  <= host.addr[6:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      table_wr_reg    <= 1'b0;
      table_wdata_reg <= 8'h00;
    end else begin
      table_wr_reg    <= host.wr && upper_hit && tsel_ok;
      table_wdata_reg <= host.wdata;
    end
  end

  // ----------------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------------
  logic [7:0] rd_mux;

  always_comb begin
    rd_mux = 8'h00;
    if (ctrl_hit) begin
      rd_mux = ctrl_value;
    end else if (upper_hit && tsel_ok) begin
      rd_mux = table_rdata;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata_reg  <= 8'h00;
      rvalid_reg <= 1'b0;
    end else begin
      rvalid_reg <= host.rd;
      if (host.rd) begin
        rdata_reg <= rd_mux;
      end
    end
  end

endmodule
`default_nettype wire

// >>> verif/lmc_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module lmc_host_model (
  input  wire logic                   clk,       // clock
  output var lmc_pkg::lmc_access_type host,      // byte access
  input  wire logic [7:0]             rdata_reg  // read data
);
  initial host = '0;
  // one byte access; idle bus shows inverted values
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge clk);
    host <= '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge clk);
    host <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    #1 q = rdata_reg;
  endtask
endmodule
`default_nettype wire

// >>> verif/lmc_regs_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module lmc_regs_monitor (
  input wire logic                    clk,             // clock
  input wire logic                    rst_n,           // sync reset
  input wire lmc_pkg::lmc_access_type host,            // host access
  input wire logic                    temp_start,      // temp start
  input wire logic                    temp_done,       // temp end
  input wire logic                    supply_start,    // supply start
  input wire logic                    supply_done,     // supply end
  input wire logic [7:0]              rdata_reg,       // read data
  input wire logic                    rvalid_reg,      // read valid
  input wire logic                    table_wr_reg,    // table write
  input wire logic [7:0]              table_wdata_reg, // table data
  input wire logic [3:0]              tsel_reg,        // table select
  input wire logic [1:0]              gp_reg           // storage bits
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire ok = tsel_reg[3:2] == 2'b01;
  property p_rd; host.rd |=> rvalid_reg; endproperty
  a_rd: assert property (p_rd) else $error("read not answered");
  property p_twr; host.wr && host.addr[7] && ok |=> table_wr_reg && table_wdata_reg == $past(host.wdata); endproperty
  a_twr: assert property (p_twr) else $error("table write lost");
  property p_notwr; host.wr && host.addr[7] && !ok |=> !table_wr_reg; endproperty
  a_notwr: assert property (p_notwr) else $error("write to unmapped table");
  property p_wctl; host.wr && host.addr == 8'h00 |=> {gp_reg, tsel_reg} == $past(host.wdata[5:0]); endproperty
  a_wctl: assert property (p_wctl) else $error("control write lost");
  property p_temp;
    temp_done ##1 (!temp_start && !(host.wr && host.addr == 8'h00)) ##1 (host.rd && host.addr == 8'h00)
      |=> rdata_reg[7];
  endproperty
  a_temp: assert property (p_temp) else $error("temp flag not set");
  property p_sup;
    supply_done ##1 (!supply_start && !(host.wr && host.addr == 8'h00)) ##1 (host.rd && host.addr == 8'h00)
      |=> rdata_reg[6];
  endproperty
  a_sup: assert property (p_sup) else $error("supply flag not set");
  property p_urd; host.rd && host.addr[7] && !ok |=> rdata_reg == 8'h00; endproperty
  a_urd: assert property (p_urd) else $error("unmapped table read not zero");
  property p_rdctl; host.rd && host.addr == 8'h00 |=> rdata_reg[5:0] == {$past(gp_reg), $past(tsel_reg)}; endproperty
  a_rdctl: assert property (p_rdctl) else $error("control read wrong");
  property p_unmap; host.rd && host.addr == 8'h08 |=> rdata_reg == 8'h00; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
endmodule
bind lmc_regs lmc_regs_monitor u_mon (.clk, .rst_n, .host, .temp_start, .temp_done, .supply_start, .supply_done,
  .rdata_reg, .rvalid_reg,
  .table_wr_reg, .table_wdata_reg, .tsel_reg, .gp_reg);
`default_nettype wire

// >>> verif/lower_memory_control_regs_bench.sv
`timescale 1ns/100ps
`default_nettype none
module lower_memory_control_regs_bench;
  logic                    clk = 1'b0;
  logic                    rst_n = 1'b0;
  logic [3:0]              ev = '0;
  lmc_pkg::lmc_access_type host;
  lmc_pkg::lmc_table_type  table_sel_reg;
  logic [7:0]              rdata_reg, table_wdata_reg, q;
  logic                    rvalid_reg, table_wr_reg;
  logic [3:0]              tsel_reg;
  logic [1:0]              gp_reg;
  int                      err_total = 0;
  int                      n_compared = 0;
  always #12.5 clk = ~clk;
  lmc_regs uut (.clk, .rst_n, .host, .temp_start(ev[0]), .temp_done(ev[1]), .supply_start(ev[2]),
    .supply_done(ev[3]), .table_rdata({1'b1, table_sel_reg.offset}), .rdata_reg, .rvalid_reg, .table_sel_reg,
    .table_wr_reg, .table_wdata_reg, .tsel_reg, .gp_reg);
  lmc_host_model hm (.clk, .host, .rdata_reg);
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic test_done;
    $display("mismatches=%0d compares=%0d", err_total, n_compared);
    if (err_total == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic pulse(input logic [3:0] v);
    @(posedge clk);
    ev <= v;
    @(posedge clk);
    ev <= '0;
  endtask
  task automatic t_reset;
    hm.acc(1'b0, 8'h00, 8'h00, q);
    chk(q, 8'h00);
    chk({7'h0, rvalid_reg}, 8'h01);
    hm.acc(1'b0, 8'h08, 8'h00, q);
    chk(q, 8'h00);
  endtask
  task automatic t_ctrl;
    hm.acc(1'b1, 8'h00, 8'h35, q);
    hm.acc(1'b0, 8'h00, 8'h00, q);
    chk(q, 8'h35);
    chk({2'b00, gp_reg, tsel_reg}, 8'h35);
  endtask
  // start clears, done sets, a written zero clears again
  task automatic t_flags;
    for (int i = 0; i < 2; i++) begin
      logic [7:0] m;
      m = (i == 0) ? 8'h80 : 8'h40;
      pulse(4'h1 << (2 * i));
      hm.acc(1'b0, 8'h00, 8'h00, q);
      chk(q & m, 8'h00);
      pulse(4'h2 << (2 * i));
      hm.acc(1'b0, 8'h00, 8'h00, q);
      chk(q & m, m);
      hm.acc(1'b1, 8'h00, 8'h35, q);
      hm.acc(1'b0, 8'h00, 8'h00, q);
      chk(q, 8'h35);
    end
  endtask
  task automatic t_tables;
    logic [3:0] bad [4];
    bad = '{4'h0, 4'h3, 4'h8, 4'hf};
    for (int c = 4; c < 8; c++) begin
      hm.acc(1'b1, 8'h00, 8'(c), q);
      hm.acc(1'b1, 8'h80 + 8'(c), 8'ha0 + 8'(c), q);
      chk({7'h0, table_wr_reg}, 8'h01);
      chk(table_wdata_reg, 8'ha0 + 8'(c));
      chk({6'h0, table_sel_reg.channel}, 8'(c - 4));
      chk({1'b0, table_sel_reg.offset}, 8'(c));
    end
    for (int k = 0; k < 4; k++) begin
      hm.acc(1'b1, 8'h00, {4'h0, bad[k]}, q);
      hm.acc(1'b1, 8'h85, 8'h5a, q);
      chk({7'h0, table_wr_reg}, 8'h00);
      hm.acc(1'b0, 8'h85, 8'h00, q);
      chk(q, 8'h00);
      chk({7'h0, table_sel_reg.valid}, 8'h00);
    end
  endtask
  // both flags set, then a reset in mid-run must bring the register back to zero
  task automatic t_midreset;
    hm.acc(1'b1, 8'h00, 8'h37, q);
    pulse(4'ha);
    hm.acc(1'b0, 8'h00, 8'h00, q);
    chk(q, 8'hf7);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    chk({2'b00, gp_reg, tsel_reg}, 8'h00);
    hm.acc(1'b0, 8'h00, 8'h00, q);
    chk(q, 8'h00);
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    t_reset;
    t_ctrl;
    t_flags;
    t_tables;
    t_midreset;
    test_done;
  end
  initial begin
    repeat (2000) @(posedge clk);
    err_total++;
    test_done;
  end
endmodule
`default_nettype wire
